// >>> rtl/identify_capability_words.sv
// identify record words 48..79 with settings registers on avalon-mm
//
// Notes on behaviour
// - identify command yields record words 48-79
// - word 49 bit 13 standby timer standard
// - word 49 bits 11,10 IORDY support
// - word 50 valid marker and standby minimum
// - words 51 and 52 read 0200h
// - word 53 validity flags 0007h
// - words 54-56 current geometry
// - words 57-58 capacity, low word first
// - word 59 multiple count and valid bit
// - words 60-61 sectors, clamped at 28 bits
// - word 63 dma modes supported and active
// - word 64 advanced PIO modes 3, 4
// - words 65, 66 report 120 ns
// - words 67, 68 report 240, 120 ns
// - word 75 queue depth in bits 4-0
// - word 76 speeds, queuing, host power requests
// - word 76 bit 10 reads zero
// - word 78 lists supported sata features
// - word 79 enabled features, default bit 6
`timescale 1ns/100ps
`include "idcap_regs.svh"
module identify_capability_words
	import idcap_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [8:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic IDENT_CMD,
	input wire logic REC_RD,
	input wire logic [4:0] REC_INDEX,
	output logic [15:0] REC_DATA,
	output logic REC_VALID,
	output logic REC_READY
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				res[i*8 +: 8] = nw[i*8 +: 8];
		end
		return res;
	endfunction : be_merge

	function automatic logic is_reg(input logic [8:0] a,
		input logic [8:0] ofs);
		return a[8:2] == ofs[8:2];
	endfunction : is_reg

	function automatic logic is_rec(input logic [8:0] a);
		return a[8:7] == `IDC_OFS_REC_BASE >> 7;
	endfunction : is_rec

	// ----------------------------------------------------------------
	// bus handshake: one wait cycle, answer on the second edge
	// ----------------------------------------------------------------
	logic ack_r;
	logic req;
	logic wr_take;
	logic [31:0] rdata_nxt;
	logic [31:0] rdata_r;

	assign req = AVS_READ | AVS_WRITE;
	assign wr_take = AVS_WRITE & ack_r;
	assign AVS_WAITREQUEST = req & ~ack_r;
	assign AVS_READDATA = rdata_r;

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			ack_r <= 1'b0;
		else
			ack_r <= req & ~ack_r;
	end

	// ----------------------------------------------------------------
	// live settings written by firmware
	// ----------------------------------------------------------------
	logic [2:0] cfg_r;
	logic [15:0] cyl_r;
	logic [15:0] heads_r;
	logic [15:0] spt_r;
	logic [31:0] cap_r;
	logic [7:0] mult_r;
	logic [47:0] nmax_r;
	logic [7:0] dma_act_r;
	logic [4:0] qdepth_r;
	logic [15:0] sata_en_r;

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			cfg_r <= `IDC_CFG_RST;
			cyl_r <= 16'h0000;
			heads_r <= 16'h0000;
			spt_r <= 16'h0000;
			cap_r <= 32'h00000000;
			mult_r <= 8'h00;
			nmax_r <= 48'h000000000000;
			dma_act_r <= 8'h00;
			qdepth_r <= 5'h00;
			sata_en_r <= `IDC_SATA_EN_RST;
		end
		else if (wr_take)
		begin
			if (is_reg(AVS_ADDRESS, `IDC_OFS_CFG))
				cfg_r <= be_merge({29'h0, cfg_r}, AVS_WRITEDATA,
					AVS_BYTEENABLE)[2:0];
			if (is_reg(AVS_ADDRESS, `IDC_OFS_CYL))
				cyl_r <= be_merge({16'h0, cyl_r}, AVS_WRITEDATA,
					AVS_BYTEENABLE)[15:0];
			if (is_reg(AVS_ADDRESS, `IDC_OFS_HEADS))
				heads_r <= be_merge({16'h0, heads_r}, AVS_WRITEDATA,
					AVS_BYTEENABLE)[15:0];
			if (is_reg(AVS_ADDRESS, `IDC_OFS_SPT))
				spt_r <= be_merge({16'h0, spt_r}, AVS_WRITEDATA,
					AVS_BYTEENABLE)[15:0];
			if (is_reg(AVS_ADDRESS, `IDC_OFS_CAP))
				cap_r <= be_merge(cap_r, AVS_WRITEDATA, AVS_BYTEENABLE);
			if (is_reg(AVS_ADDRESS, `IDC_OFS_MULT))
				mult_r <= be_merge({24'h0, mult_r}, AVS_WRITEDATA,
					AVS_BYTEENABLE)[7:0];
			if (is_reg(AVS_ADDRESS, `IDC_OFS_NMAX_LO))
				nmax_r[31:0] <= be_merge(nmax_r[31:0], AVS_WRITEDATA,
					AVS_BYTEENABLE);
			if (is_reg(AVS_ADDRESS, `IDC_OFS_NMAX_HI))
				nmax_r[47:32] <= be_merge({16'h0, nmax_r[47:32]},
					AVS_WRITEDATA, AVS_BYTEENABLE)[15:0];
			if (is_reg(AVS_ADDRESS, `IDC_OFS_DMA_ACT))
				dma_act_r <= be_merge({24'h0, dma_act_r}, AVS_WRITEDATA,
					AVS_BYTEENABLE)[7:0];
			if (is_reg(AVS_ADDRESS, `IDC_OFS_QDEPTH))
				qdepth_r <= be_merge({27'h0, qdepth_r}, AVS_WRITEDATA,
					AVS_BYTEENABLE)[4:0];
			if (is_reg(AVS_ADDRESS, `IDC_OFS_SATA_EN))
				sata_en_r <= be_merge({16'h0, sata_en_r}, AVS_WRITEDATA,
					AVS_BYTEENABLE)[15:0];
		end
	end

	// ----------------------------------------------------------------
	// record assembly: capture settings in force at command time
	// ----------------------------------------------------------------
	logic snap_ev;
	logic ready_r;
	logic [7:0] snap_cnt_r;
	snapshot_t snap_r;
	snapshot_t live;

	// firmware may also trigger assembly, e.g. after a settings change
	assign snap_ev = IDENT_CMD | (wr_take &
		is_reg(AVS_ADDRESS, `IDC_OFS_CMD) &
		AVS_BYTEENABLE[0] & AVS_WRITEDATA[`IDC_CMD_SNAP_BIT]);

	always_comb
	begin
		live.std = cfg_r[`IDC_CFG_STD_BIT];
		live.ge5 = cfg_r[`IDC_CFG_GE5_BIT];
		live.cyl = cyl_r;
		live.heads = heads_r;
		live.spt = spt_r;
		live.cap = cap_r;
		live.mult_valid = cfg_r[`IDC_CFG_MVALID_BIT];
		live.mult = mult_r;
		live.nmax = nmax_r;
		live.dma_act = dma_act_r;
		live.qdepth = qdepth_r;
		live.sata_en = sata_en_r;
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			snap_r <= '0;
		else if (snap_ev)
			snap_r <= live;
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			ready_r <= 1'b0;
			snap_cnt_r <= 8'h00;
		end
		else if (snap_ev)
		begin
			ready_r <= 1'b1;
			snap_cnt_r <= snap_cnt_r + 8'h01;
		end
	end

	assign REC_READY = ready_r;

	// ----------------------------------------------------------------
	// word encoders: port 0 serves the sector stream, port 1 the bus
	// ----------------------------------------------------------------
	idcap_if lnk[2] ();

	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_enc
			assign lnk[g].snap = snap_r;
			idcap_word_enc u_enc (.lnk(lnk[g]));
		end
	endgenerate

	assign lnk[0].idx = REC_INDEX;
	assign lnk[1].idx = AVS_ADDRESS[6:2];

	// ----------------------------------------------------------------
	// record word port toward the transfer logic
	// ----------------------------------------------------------------
	logic [15:0] rec_data_r;
	logic rec_valid_r;

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			rec_data_r <= 16'h0000;
			rec_valid_r <= 1'b0;
		end
		else
		begin
			rec_valid_r <= REC_RD;
			if (REC_RD)
				rec_data_r <= lnk[0].word;
		end
	end

	assign REC_DATA = rec_data_r;
	assign REC_VALID = rec_valid_r;

	// ----------------------------------------------------------------
	// bus read data; unmapped offsets read zero, writes there dropped
	// ----------------------------------------------------------------
	always_comb
	begin
		rdata_nxt = 32'h00000000;
		if (is_rec(AVS_ADDRESS))
			rdata_nxt = {16'h0000, lnk[1].word};
		else if (is_reg(AVS_ADDRESS, `IDC_OFS_CFG))
			rdata_nxt = {29'h0, cfg_r};
		else if (is_reg(AVS_ADDRESS, `IDC_OFS_STAT))
			rdata_nxt = {16'h0, snap_cnt_r, 7'h0, ready_r};
		else if (is_reg(AVS_ADDRESS, `IDC_OFS_CYL))
			rdata_nxt = {16'h0, cyl_r};
		else if (is_reg(AVS_ADDRESS, `IDC_OFS_HEADS))
			rdata_nxt = {16'h0, heads_r};
		else if (is_reg(AVS_ADDRESS, `IDC_OFS_SPT))
			rdata_nxt = {16'h0, spt_r};
		else if (is_reg(AVS_ADDRESS, `IDC_OFS_CAP))
			rdata_nxt = cap_r;
		else if (is_reg(AVS_ADDRESS, `IDC_OFS_MULT))
			rdata_nxt = {24'h0, mult_r};
		else if (is_reg(AVS_ADDRESS, `IDC_OFS_NMAX_LO))
			rdata_nxt = nmax_r[31:0];
		else if (is_reg(AVS_ADDRESS, `IDC_OFS_NMAX_HI))
			rdata_nxt = {16'h0, nmax_r[47:32]};
		else if (is_reg(AVS_ADDRESS, `IDC_OFS_DMA_ACT))
			rdata_nxt = {24'h0, dma_act_r};
		else if (is_reg(AVS_ADDRESS, `IDC_OFS_QDEPTH))
			rdata_nxt = {27'h0, qdepth_r};
		else if (is_reg(AVS_ADDRESS, `IDC_OFS_SATA_EN))
			rdata_nxt = {16'h0, sata_en_r};
	end

	// data is latched on the wait cycle so it stands at the answer edge
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			rdata_r <= 32'h00000000;
		else if (AVS_READ & ~ack_r)
			rdata_r <= rdata_nxt;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	bus_answer_a: assert property (@(posedge CLK) disable iff (!RESETN)
		req & ~ack_r |=> !AVS_WAITREQUEST)
		else $error("bus request not answered after one wait cycle");

	rec_valid_a: assert property (@(posedge CLK) disable iff (!RESETN)
		REC_RD |=> REC_VALID ##1 (REC_VALID == $past(REC_RD)))
		else $error("record read not answered next cycle");

	cap_word_a: assert property (@(posedge CLK) disable iff (!RESETN)
		REC_RD && REC_INDEX == 5'h01 |=>
		REC_DATA[`IDC_W49_STD_BIT] == $past(snap_r.std))
		else $error("standby timer bit wrong");

	iordy_bits_a: assert property (@(posedge CLK) disable iff (!RESETN)
		REC_RD && REC_INDEX == 5'h01 |=> REC_DATA[11:10] == 2'h3)
		else $error("iordy bits not set");

	w50_valid_a: assert property (@(posedge CLK) disable iff (!RESETN)
		REC_RD && REC_INDEX == 5'h02 |=>
		REC_DATA == (`IDC_W50_FIXED | 16'($past(snap_r.ge5))))
		else $error("word 50 wrong");

	valid_flags_a: assert property (@(posedge CLK) disable iff (!RESETN)
		REC_RD && REC_INDEX == 5'h05 |=> REC_DATA == `IDC_W53_VALID)
		else $error("word 53 wrong");

	mult_word_a: assert property (@(posedge CLK) disable iff (!RESETN)
		REC_RD && REC_INDEX == 5'h0B |=> REC_DATA[15:9] == 7'h00 &&
		REC_DATA[7:0] == $past(snap_r.mult))
		else $error("word 59 wrong");

	lba_clamp_a: assert property (@(posedge CLK) disable iff (!RESETN)
		REC_RD && REC_INDEX == 5'h0D && snap_r.nmax > `IDC_LBA28_MAX
		|=> REC_DATA == `IDC_LBA28_CLAMP >> 16)
		else $error("sector count not clamped");

	sata_cap_a: assert property (@(posedge CLK) disable iff (!RESETN)
		REC_RD && REC_INDEX == 5'h1C |=> !REC_DATA[10] &&
		REC_DATA == `IDC_W76_SATA_CAP)
		else $error("word 76 wrong");

	sata_en_a: assert property (@(posedge CLK) disable iff (!RESETN)
		REC_RD && REC_INDEX == 5'h1F |=>
		REC_DATA == ($past(snap_r.sata_en) & `IDC_W78_SATA_SUPP))
		else $error("word 79 wrong");

	snap_take_a: assert property (@(posedge CLK) disable iff (!RESETN)
		snap_ev |=> snap_r.cyl == $past(cyl_r) &&
		snap_r.cap == $past(cap_r) && REC_READY)
		else $error("settings not captured");

	snap_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
		!snap_ev |=> $stable(snap_r))
		else $error("captured record changed without command");

	rsvd_zero_a: assert property (@(posedge CLK) disable iff (!RESETN)
		REC_RD && (REC_INDEX == 5'h00 || REC_INDEX == 5'h0E ||
		REC_INDEX == 5'h1D) |=> REC_DATA == 16'h0000)
		else $error("reserved word not zero");

endmodule : identify_capability_words

// >>> rtl/idcap_regs.svh
// register offsets, field positions and fixed word values of the id block
`ifndef IDCAP_REGS_SVH
`define IDCAP_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define IDC_OFS_CFG 9'h000
`define IDC_OFS_CMD 9'h004
`define IDC_OFS_STAT 9'h008
`define IDC_OFS_CYL 9'h00C
`define IDC_OFS_HEADS 9'h010
`define IDC_OFS_SPT 9'h014
`define IDC_OFS_CAP 9'h018
`define IDC_OFS_MULT 9'h01C
`define IDC_OFS_NMAX_LO 9'h020
`define IDC_OFS_NMAX_HI 9'h024
`define IDC_OFS_DMA_ACT 9'h028
`define IDC_OFS_QDEPTH 9'h02C
`define IDC_OFS_SATA_EN 9'h030
`define IDC_OFS_REC_BASE 9'h100

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define IDC_CFG_STD_BIT 0
`define IDC_CFG_GE5_BIT 1
`define IDC_CFG_MVALID_BIT 2
`define IDC_CMD_SNAP_BIT 0
`define IDC_STAT_READY_BIT 0
`define IDC_W49_STD_BIT 13

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define IDC_CFG_RST 3'h1
`define IDC_SATA_EN_RST 16'h0040

// ----------------------------------------------------------------
// fixed record words
// ----------------------------------------------------------------
`define IDC_W49_FIXED 16'h0E00
`define IDC_W50_FIXED 16'h4000
`define IDC_W51_PIO 16'h0200
`define IDC_W52_DMA 16'h0200
`define IDC_W53_VALID 16'h0007
`define IDC_W63_SUPP 8'h07
`define IDC_W64_APIO 16'h0003
`define IDC_MWDMA_MIN_NS 16'h0078
`define IDC_MWDMA_REC_NS 16'h0078
`define IDC_PIO_MIN_NS 16'h00F0
`define IDC_PIO_IORDY_NS 16'h0078
`define IDC_W76_SATA_CAP 16'h0306
`define IDC_W78_SATA_SUPP 16'h005E
`define IDC_LBA28_MAX 48'h00000FFFFFFF
`define IDC_LBA28_CLAMP 32'h0FFFFFFF

`endif

// >>> rtl/idcap_pkg.sv
// types shared by the identify capability word block
package idcap_pkg;

	typedef logic [15:0] idword_t;

	typedef struct packed
	{
		logic std;
		logic ge5;
		logic [15:0] cyl;
		logic [15:0] heads;
		logic [15:0] spt;
		logic [31:0] cap;
		logic mult_valid;
		logic [7:0] mult;
		logic [47:0] nmax;
		logic [7:0] dma_act;
		logic [4:0] qdepth;
		logic [15:0] sata_en;
	} snapshot_t;

endpackage : idcap_pkg

// >>> rtl/idcap_if.sv
// link between the record owner and a word encoder
`timescale 1ns/100ps
interface idcap_if;
	import idcap_pkg::*;
	snapshot_t snap;
	logic [4:0] idx;
	idword_t word;
	modport src (output snap, output idx, input word);
	modport enc (input snap, input idx, output word);
endinterface : idcap_if

// >>> rtl/idcap_word_enc.sv
// encoder of one record word (48..79) from the captured settings
`timescale 1ns/100ps
`include "idcap_regs.svh"
module idcap_word_enc
	import idcap_pkg::*;
(
	idcap_if.enc lnk
);
	logic [31:0] total;

	// ----------------------------------------------------------------
	// total addressable sectors, clamped to 28 bits
	// ----------------------------------------------------------------
	always_comb
	begin
		if (lnk.snap.nmax > `IDC_LBA28_MAX)
			total = `IDC_LBA28_CLAMP;
		else
			total = lnk.snap.nmax[31:0];
	end

	// ----------------------------------------------------------------
	// word select; index 0 is word 48
	// ----------------------------------------------------------------
	always_comb
	begin
		unique case (lnk.idx)
			5'h01: lnk.word = `IDC_W49_FIXED |
				(16'(lnk.snap.std) << `IDC_W49_STD_BIT);
			5'h02: lnk.word = `IDC_W50_FIXED | 16'(lnk.snap.ge5);
			5'h03: lnk.word = `IDC_W51_PIO;
			5'h04: lnk.word = `IDC_W52_DMA;
			5'h05: lnk.word = `IDC_W53_VALID;
			5'h06: lnk.word = lnk.snap.cyl;
			5'h07: lnk.word = lnk.snap.heads;
			5'h08: lnk.word = lnk.snap.spt;
			5'h09: lnk.word = lnk.snap.cap[15:0];
			5'h0A: lnk.word = lnk.snap.cap[31:16];
			5'h0B: lnk.word = {7'h00, lnk.snap.mult_valid,
				lnk.snap.mult};
			5'h0C: lnk.word = total[15:0];
			5'h0D: lnk.word = total[31:16];
			5'h0F: lnk.word = {lnk.snap.dma_act, `IDC_W63_SUPP};
			5'h10: lnk.word = `IDC_W64_APIO;
			5'h11: lnk.word = `IDC_MWDMA_MIN_NS;
			5'h12: lnk.word = `IDC_MWDMA_REC_NS;
			5'h13: lnk.word = `IDC_PIO_MIN_NS;
			5'h14: lnk.word = `IDC_PIO_IORDY_NS;
			5'h1B: lnk.word = {11'h000, lnk.snap.qdepth};
			5'h1C: lnk.word = `IDC_W76_SATA_CAP;
			5'h1E: lnk.word = `IDC_W78_SATA_SUPP;
			5'h1F: lnk.word = lnk.snap.sata_en &
				`IDC_W78_SATA_SUPP;
			// words 48, 62, 69-74 and 77
			default: lnk.word = 16'h0000;
		endcase
	end

endmodule : idcap_word_enc

// >>> dv/host_model.sv
// host-side reader of the identify record words 48..79
`timescale 1ns/100ps
module host_model
	import idcap_pkg::*;
(
	input wire logic CLK,
	output logic IDENT_CMD,
	output logic REC_RD,
	output logic [4:0] REC_INDEX,
	input wire logic [15:0] REC_DATA,
	input wire logic REC_VALID
);
	idword_t sector [0:31];
	logic [4:0] pend_r;

	initial
	begin
		IDENT_CMD = 1'b0;
		REC_RD = 1'b0;
		REC_INDEX = 5'h00;
		pend_r = 5'h00;
	end

	// one answer per request, so the pending index pairs with the word
	always @(posedge CLK)
	begin
		if (REC_VALID === 1'b1)
			sector[pend_r] <= REC_DATA;
		if (REC_RD)
			pend_r <= REC_INDEX;
	end

	task identify;
		IDENT_CMD <= 1'b1;
		@(posedge CLK);
		IDENT_CMD <= 1'b0;
		@(posedge CLK);
	endtask : identify

	// gap 0 streams one word a cycle; released index is inverted, not held
	task read_sector(input int gap);
		for (int i = 0; i < 32; i++)
		begin
			REC_RD <= 1'b1;
			REC_INDEX <= i[4:0];
			@(posedge CLK);
			if (gap > 0 || i == 31)
			begin
				REC_RD <= 1'b0;
				REC_INDEX <= ~i[4:0];
				repeat (gap) @(posedge CLK);
			end
		end
		repeat (2) @(posedge CLK);
	endtask : read_sector
endmodule : host_model

// >>> dv/identify_capability_words_test.sv
// self-checking bench of the identify capability word block
`timescale 1ns/100ps
module identify_capability_words_test;
	import idcap_pkg::*;
	logic CLK, RESETN, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
	logic [8:0] AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA;
	logic [3:0] AVS_BYTEENABLE;
	logic IDENT_CMD, REC_RD, REC_VALID, REC_READY;
	logic [4:0] REC_INDEX;
	logic [15:0] REC_DATA;
	int error_cnt = 0;
	int total_checks = 0;
	snapshot_t s, n;

	identify_capability_words dut_u (.CLK(CLK), .RESETN(RESETN),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .IDENT_CMD(IDENT_CMD),
		.REC_RD(REC_RD), .REC_INDEX(REC_INDEX), .REC_DATA(REC_DATA),
		.REC_VALID(REC_VALID), .REC_READY(REC_READY));
	host_model host_u (.CLK(CLK), .IDENT_CMD(IDENT_CMD), .REC_RD(REC_RD),
		.REC_INDEX(REC_INDEX), .REC_DATA(REC_DATA), .REC_VALID(REC_VALID));

	// ----------------------------------------------------------------
	// expectations and compares
	// ----------------------------------------------------------------
	function automatic idword_t exp_word(snapshot_t e, int i);
		logic [31:0] tot;
		tot = (e.nmax > 48'h00000FFFFFFF) ? 32'h0FFFFFFF : e.nmax[31:0];
		case (i)
			1: return 16'h0E00 | {2'h0, e.std, 13'h0000};
			2: return 16'h4000 | {15'h0000, e.ge5};
			3, 4: return 16'h0200;
			5: return 16'h0007;
			6: return e.cyl;
			7: return e.heads;
			8: return e.spt;
			9: return e.cap[15:0];
			10: return e.cap[31:16];
			11: return {7'h00, e.mult_valid, e.mult};
			12: return tot[15:0];
			13: return tot[31:16];
			15: return {e.dma_act, 8'h07};
			16: return 16'h0003;
			17, 18, 20: return 16'h0078;
			19: return 16'h00F0;
			27: return {11'h000, e.qdepth};
			28: return 16'h0306;
			30: return 16'h005E;
			31: return e.sata_en & 16'h005E;
			default: return 16'h0000;
		endcase
	endfunction : exp_word

	task chk_word(input idword_t got, input idword_t exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: word %h want %h", $time, got, exp);
		end
	endtask : chk_word

	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: reg %h want %h", $time, got, exp);
		end
	endtask : chk_reg

	task check_sector(snapshot_t e);
		for (int i = 0; i < 32; i++)
			chk_word(host_u.sector[i], exp_word(e, i));
	endtask : check_sector

	// ----------------------------------------------------------------
	// avalon master
	// ----------------------------------------------------------------
	// waitrequest is combinational, so it is sampled mid-cycle
	task avs_req(input logic [8:0] a, input logic wr, input logic [31:0] d,
		output logic [31:0] q);
		int k;
		logic w;
		k = 0;
		w = 1'b1;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= wr;
		AVS_READ <= ~wr;
		while (w !== 1'b0)
		begin
			@(negedge CLK);
			w = AVS_WAITREQUEST;
			q = AVS_READDATA;
			@(posedge CLK);
			k++;
			if (k > 16 && w !== 1'b0)
			begin
				error_cnt++;
				$display("unexpected at %0t: bus hang", $time);
				w = 1'b0;
			end
		end
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		@(posedge CLK);
	endtask : avs_req

	task avs_write(input logic [8:0] a, input logic [31:0] d);
		logic [31:0] q;
		avs_req(a, 1'b1, d, q);
	endtask : avs_write

	task rd_chk(input logic [8:0] a, input logic [31:0] exp);
		logic [31:0] q;
		avs_req(a, 1'b0, 32'h00000000, q);
		chk_reg(q, exp);
	endtask : rd_chk

	task load(snapshot_t e);
		avs_write(9'h000, {29'h0, e.mult_valid, e.ge5, e.std});
		avs_write(9'h00C, {16'h0000, e.cyl});
		avs_write(9'h010, {16'h0000, e.heads});
		avs_write(9'h014, {16'h0000, e.spt});
		avs_write(9'h018, e.cap);
		avs_write(9'h01C, {24'h000000, e.mult});
		avs_write(9'h020, e.nmax[31:0]);
		avs_write(9'h024, {16'h0000, e.nmax[47:32]});
		avs_write(9'h028, {24'h000000, e.dma_act});
		avs_write(9'h02C, {27'h0, e.qdepth});
		avs_write(9'h030, {16'h0000, e.sata_en});
	endtask : load

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_reset;
		rd_chk(9'h000, 32'h00000001);
		rd_chk(9'h030, 32'h00000040);
		avs_write(9'h03C, 32'hFFFFFFFF);
		rd_chk(9'h03C, 32'h00000000);
		rd_chk(9'h104, 32'h00000E00);
		$display("test reset done");
	endtask : t_reset

	task t_default;
		s = '0;
		s.std = 1'b1;
		s.sata_en = 16'h0040;
		host_u.identify();
		host_u.read_sector(0);
		check_sector(s);
		$display("test default record done");
	endtask : t_default

	// nmax just above 28 bits must clamp
	task t_program;
		s.std = 1'b0;
		s.ge5 = 1'b1;
		s.mult_valid = 1'b1;
		s.cyl = 16'h3FFF;
		s.heads = 16'h000F;
		s.spt = 16'h003F;
		s.cap = 32'h12345678;
		s.mult = 8'h10;
		s.nmax = 48'h000010000000;
		s.dma_act = 8'h04;
		s.qdepth = 5'h1F;
		s.sata_en = 16'hFFFF;
		load(s);
		avs_write(9'h004, 32'h00000001);
		host_u.read_sector(3);
		check_sector(s);
		rd_chk(9'h008, 32'h00000201);
		$display("test programmed record done");
	endtask : t_program

	task t_capture;
		n = s;
		n.cyl = 16'h0BAD;
		n.nmax = 48'h00000FFFFFFF;
		n.sata_en = 16'h0000;
		n.mult_valid = 1'b0;
		load(n);
		host_u.read_sector(0);
		check_sector(s);
		host_u.identify();
		host_u.read_sector(1);
		check_sector(n);
		rd_chk(9'h130, 32'h0000FFFF);
		rd_chk(9'h134, 32'h00000FFF);
		$display("test capture done");
	endtask : t_capture

	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	// ----------------------------------------------------------------
	// clock, reset, sequence
	// ----------------------------------------------------------------
	initial
	begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end

	initial
	begin
		repeat (6000) @(posedge CLK);
		error_cnt++;
		finish_test();
	end

	initial
	begin
		RESETN = 1'b0;
		AVS_ADDRESS = 9'h000;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_WRITEDATA = 32'h00000000;
		AVS_BYTEENABLE = 4'hF;
		repeat (6) @(posedge CLK);
		RESETN <= 1'b1;
		@(posedge CLK);
		t_reset();
		t_default();
		t_program();
		t_capture();
		finish_test();
	end
endmodule : identify_capability_words_test
